/* File: src/mlt_pkg.sv */
// constants, types and register map of the multi-length timer base
package mlt_pkg;

   // widths
   localparam int ADDR_W = 8;
   localparam int CNT_W = 16;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_CHZ = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0C;
   localparam logic [7:0] OFS_PERIOD = 8'h10;

   // field positions
   localparam int CLR_BIT = 2;
   localparam int FLG_OVF_BIT = 0;
   localparam int FLG_CHZ_BIT = 1;

   // values after reset
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'h0000;

   // length-dependent maximum counts
   localparam logic [15:0] MAX_16 = 16'hFFFF;
   localparam logic [15:0] MAX_12 = 16'h0FFF;
   localparam logic [15:0] MAX_10 = 16'h03FF;
   localparam logic [15:0] MAX_8 = 16'h00FF;

   // count length codes
   localparam logic [1:0] LEN_16 = 2'h0;
   localparam logic [1:0] LEN_12 = 2'h1;
   localparam logic [1:0] LEN_10 = 2'h2;
   localparam logic [1:0] LEN_8 = 2'h3;

   // clock source codes
   localparam logic [1:0] SRC_AUX = 2'h0;
   localparam logic [1:0] SRC_SUB = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h2;
   localparam logic [1:0] SRC_EXT_INV = 2'h3;

   // divider codes and their edge masks
   localparam logic [1:0] DIV_1 = 2'h0;
   localparam logic [1:0] DIV_2 = 2'h1;
   localparam logic [1:0] DIV_4 = 2'h2;
   localparam logic [1:0] DIV_8 = 2'h3;
   localparam logic [2:0] DMASK_1 = 3'h0;
   localparam logic [2:0] DMASK_2 = 3'h1;
   localparam logic [2:0] DMASK_4 = 3'h3;
   localparam logic [2:0] DMASK_8 = 3'h7;

   // mode control field codes
   localparam logic [1:0] MC_STOP = 2'h0;
   localparam logic [1:0] MC_UP = 2'h1;
   localparam logic [1:0] MC_CONT = 2'h2;
   localparam logic [1:0] MC_UPDN = 2'h3;

   // period load select codes
   localparam logic [1:0] PLS_IMM = 2'h0;
   localparam logic [1:0] PLS_ZERO = 2'h1;
   localparam logic [1:0] PLS_ZERO_PEAK = 2'h2;

   // decoded operating mode, one-hot
   typedef enum logic [3:0] {
      MODE_STOP = 4'h1,
      MODE_UP = 4'h2,
      MODE_CONT = 4'h4,
      MODE_UPDN = 4'h8
   } mlt_mode_e;

   // control register layout
   typedef struct packed {
      logic out_hiz;
      logic [1:0] period_load_select;
      logic [1:0] count_length_select;
      logic rsvd_10;
      logic [1:0] clock_source_select;
      logic [1:0] input_divider_select;
      logic [1:0] mode_control_field;
      logic rsvd_3;
      logic counter_clear_bit;
      logic [1:0] rsvd_1_0;
   } mlt_ctrl_s;

   // register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [CNT_W-1:0] wdata;
      logic wr;
      logic rd;
   } mlt_bus_s;

endpackage

/* File: src/mlt_timer_base.sv */
// multi-length timer base: counter, clock select, divider, modes, flags
//
// Overview of operation
// - count moves by one on each selected timer clock edge, up or down
// - software reads and writes the count; a write lands at once
// - clear bit zeroes count, divider and up/down direction
// - length select picks 8, 10, 12 or 16 bits with matching maximum
// - written count is right-aligned, bits above the length held zero
// - source select picks auxiliary, sub-main, external or inverted external
// - divider passes the clock or divides it by 2, 4 or 8
// - counting only with nonzero mode and an active clock source
// - zero period stops up and up/down; a nonzero immediate load restarts from zero upward
// - mode 00 halt, 01 up, 10 continuous, 11 up/down
// - up mode counts zero to period and restarts, period plus one counts
// - entering up mode above the period restarts the count from zero
// - up mode: channel flag at period, overflow flag on period to zero
// - immediate period load: count to larger period, roll if below count
// - continuous mode wraps at length maximum; channel zero compares only
// - continuous mode sets overflow flag on maximum to zero
// - up/down mode counts zero to period then back to zero
// - flags come only from counting, never from software count writes
// - the timer output can be put in high impedance
// - up/down: channel flag on period-1 to period, overflow on 1 to 0
// - up/down direction is latched and survives a halt
// - up/down with period above maximum behaves as continuous mode
`timescale 1ns/1ps
module mlt_timer_base (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [mlt_pkg::ADDR_W-1:0] addr,
   input wire logic [mlt_pkg::CNT_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [mlt_pkg::CNT_W-1:0] rdata,
   input wire logic aux_clock,
   input wire logic sub_main_clock,
   input wire logic external_timer_clock_pin,
   output logic [mlt_pkg::CNT_W-1:0] count_value,
   output logic [mlt_pkg::CNT_W-1:0] period_value,
   output logic equ0,
   output logic overflow_interrupt_flag,
   output logic channel_interrupt_flag,
   output logic timer_out,
   output logic timer_out_oe
);

   // reset release synchroniser
   logic [1:0] rst_sync_r;
   logic rst_int_n;

   // bus request bundle
   mlt_pkg::mlt_bus_s bus;

   // configuration and state
   mlt_pkg::mlt_ctrl_s ctrl_r;
   mlt_pkg::mlt_ctrl_s ctrl_wr;
   mlt_pkg::mlt_mode_e mode;
   logic [15:0] cnt_r;
   logic [15:0] per_r;
   logic [15:0] per_nxt;
   logic [15:0] per_buf_r;
   logic load_pend_r;
   logic dir_down_r;
   logic [2:0] div_r;
   logic src_prev_r;
   logic ovf_flag_r;
   logic chz_flag_r;
   logic equ0_r;
   logic out_r;
   logic [15:0] rdata_r;

   // decoded strobes and combinational terms
   logic wr_ctrl;
   logic wr_count;
   logic wr_chz;
   logic wr_flags;
   logic clear_pulse;
   logic src_level;
   logic src_edge;
   logic [2:0] div_mask;
   logic run;
   logic tick;
   logic [15:0] len_max;
   logic [15:0] cnt_inc;
   logic [15:0] cnt_dec;
   logic [15:0] cnt_step;
   logic dir_step;
   logic ovf_evt;
   logic chz_evt;
   logic peak_evt;
   logic zero_evt;
   logic load_imm;
   logic load_evt;
   logic per_load;
   logic restart;
   logic period_mode;

   // two-flop release of the asynchronous reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync_r[1];

   // address decode
   assign bus = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};
   assign wr_ctrl = bus.wr && (bus.addr == mlt_pkg::OFS_CTRL);
   assign wr_count = bus.wr && (bus.addr == mlt_pkg::OFS_COUNT);
   assign wr_chz = bus.wr && (bus.addr == mlt_pkg::OFS_CHZ);
   assign wr_flags = bus.wr && (bus.addr == mlt_pkg::OFS_FLAGS);
   assign ctrl_wr = mlt_pkg::mlt_ctrl_s'(bus.wdata);
   assign clear_pulse = wr_ctrl && ctrl_wr.counter_clear_bit;

   // control register; clear bit is a self-clearing strobe
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         ctrl_r <= mlt_pkg::mlt_ctrl_s'(mlt_pkg::CTRL_RST);
      end else if (wr_ctrl) begin
         ctrl_r <= ctrl_wr;
         ctrl_r.counter_clear_bit <= 1'b0;
         ctrl_r.rsvd_10 <= 1'b0;
         ctrl_r.rsvd_3 <= 1'b0;
         ctrl_r.rsvd_1_0 <= 2'h0;
      end
   end

   // mode decode
   // mode decode
   always_comb begin
      case (ctrl_r.mode_control_field)
         mlt_pkg::MC_STOP: mode = mlt_pkg::MODE_STOP;
         mlt_pkg::MC_UP: mode = mlt_pkg::MODE_UP;
         mlt_pkg::MC_CONT: mode = mlt_pkg::MODE_CONT;
         mlt_pkg::MC_UPDN: mode = mlt_pkg::MODE_UPDN;
         default: mode = mlt_pkg::MODE_STOP;
      endcase
   end

   // length maximum
   // length maximum
   always_comb begin
      case (ctrl_r.count_length_select)
         mlt_pkg::LEN_16: len_max = mlt_pkg::MAX_16;
         mlt_pkg::LEN_12: len_max = mlt_pkg::MAX_12;
         mlt_pkg::LEN_10: len_max = mlt_pkg::MAX_10;
         mlt_pkg::LEN_8: len_max = mlt_pkg::MAX_8;
         default: len_max = mlt_pkg::MAX_16;
      endcase
   end

   // clock source select
   // source mux
   always_comb begin
      case (ctrl_r.clock_source_select)
         mlt_pkg::SRC_AUX: src_level = aux_clock;
         mlt_pkg::SRC_SUB: src_level = sub_main_clock;
         mlt_pkg::SRC_EXT: src_level = external_timer_clock_pin;
         mlt_pkg::SRC_EXT_INV: src_level = ~external_timer_clock_pin;
         default: src_level = aux_clock;
      endcase
   end

   // divider edge mask
   always_comb begin
      case (ctrl_r.input_divider_select)
         mlt_pkg::DIV_1: div_mask = mlt_pkg::DMASK_1;
         mlt_pkg::DIV_2: div_mask = mlt_pkg::DMASK_2;
         mlt_pkg::DIV_4: div_mask = mlt_pkg::DMASK_4;
         mlt_pkg::DIV_8: div_mask = mlt_pkg::DMASK_8;
         default: div_mask = mlt_pkg::DMASK_1;
      endcase
   end

   // rising edge of the selected source
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         src_prev_r <= 1'b0;
      end else begin
         src_prev_r <= src_level;
      end
   end
   assign src_edge = src_level && !src_prev_r;

   // run condition
   assign period_mode = (mode == mlt_pkg::MODE_UP) ||
                        (mode == mlt_pkg::MODE_UPDN);
   assign run = (mode != mlt_pkg::MODE_STOP) &&
                !(period_mode && (per_r == 16'h0000));

   // clock divider
   // divider
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         div_r <= 3'h0;
      end else if (clear_pulse) begin
         div_r <= 3'h0;
      end else if (src_edge && run) begin
         div_r <= 3'(div_r + 3'h1);
      end
   end
   assign tick = src_edge && run && ((div_r & div_mask) == div_mask);

   // next count on a tick
   assign cnt_inc = 16'(cnt_r + 16'h0001);
   assign cnt_dec = 16'(cnt_r - 16'h0001);
   always_comb begin
      cnt_step = cnt_r;
      dir_step = dir_down_r;
      ovf_evt = 1'b0;
      chz_evt = 1'b0;
      peak_evt = 1'b0;
      case (mode)
         mlt_pkg::MODE_UP: begin
            if (cnt_r >= per_r) begin
               cnt_step = 16'h0000;
               ovf_evt = (cnt_r == per_r);
            end else begin
               cnt_step = cnt_inc;
               chz_evt = (cnt_inc == per_r);
            end
         end
         mlt_pkg::MODE_CONT: begin
            if (cnt_r >= len_max) begin
               cnt_step = 16'h0000;
               ovf_evt = 1'b1;
            end else begin
               cnt_step = cnt_inc;
            end
            chz_evt = (cnt_step == per_r);
         end
         mlt_pkg::MODE_UPDN: begin
            if (per_r > len_max) begin
               if (cnt_r >= len_max) begin
                  cnt_step = 16'h0000;
                  ovf_evt = 1'b1;
               end else begin
                  cnt_step = cnt_inc;
               end
               chz_evt = (cnt_step == per_r);
            end else if (!dir_down_r) begin
               if (cnt_r >= per_r) begin
                  cnt_step = cnt_dec;
                  dir_step = 1'b1;
               end else begin
                  cnt_step = cnt_inc;
                  if (cnt_inc == per_r) begin
                     chz_evt = 1'b1;
                     peak_evt = 1'b1;
                     dir_step = 1'b1;
                  end
               end
            end else if (cnt_r == 16'h0000) begin
               cnt_step = cnt_inc;
               dir_step = 1'b0;
            end else begin
               cnt_step = cnt_dec;
               if (cnt_r == 16'h0001) begin
                  ovf_evt = 1'b1;
                  dir_step = 1'b0;
               end
            end
         end
         default: begin
            cnt_step = cnt_r;
         end
      endcase
   end
   assign zero_evt = tick && (cnt_step == 16'h0000);

   // period buffer and latch transfer
   assign load_imm = wr_chz &&
                     (ctrl_r.period_load_select == mlt_pkg::PLS_IMM);
   assign load_evt = load_pend_r && (zero_evt ||
                     ((ctrl_r.period_load_select ==
                       mlt_pkg::PLS_ZERO_PEAK) &&
                      (mode == mlt_pkg::MODE_UPDN) && tick && peak_evt));
   assign per_load = load_imm || load_evt;
   assign per_nxt = load_imm ? bus.wdata : per_buf_r;
   assign restart = per_load && period_mode && (per_r == 16'h0000) &&
                    (per_nxt != 16'h0000);

   // buffer written by software
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         per_buf_r <= mlt_pkg::PERIOD_RST;
      end else if (wr_chz) begin
         per_buf_r <= bus.wdata;
      end
   end

   // pending transfer; a new write wins over a transfer
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         load_pend_r <= 1'b0;
      end else if (wr_chz && !load_imm) begin
         load_pend_r <= 1'b1;
      end else if (load_evt || load_imm) begin
         load_pend_r <= 1'b0;
      end
   end

   // period latch
   // immediate or buffered load
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         per_r <= mlt_pkg::PERIOD_RST;
      end else if (per_load) begin
         per_r <= per_nxt;
      end
   end

   // count register
   // count update
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         cnt_r <= mlt_pkg::COUNT_RST;
      end else if (clear_pulse) begin
         cnt_r <= 16'h0000;
      end else if (wr_count) begin
         cnt_r <= bus.wdata & len_max;
      end else if (restart) begin
         cnt_r <= 16'h0000;
      end else if (tick) begin
         cnt_r <= cnt_step & len_max;
      end
   end

   // latched up/down direction
   // direction latch
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         dir_down_r <= 1'b0;
      end else if (clear_pulse || restart) begin
         dir_down_r <= 1'b0;
      end else if (tick) begin
         dir_down_r <= dir_step;
      end
   end

   // sticky flags; write one clears, a set in the same cycle wins
   // count-only flags
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         ovf_flag_r <= 1'b0;
         chz_flag_r <= 1'b0;
      end else begin
         ovf_flag_r <= (ovf_flag_r &&
                        !(wr_flags && bus.wdata[mlt_pkg::FLG_OVF_BIT])) ||
                       (tick && ovf_evt && !wr_count);
         chz_flag_r <= (chz_flag_r &&
                        !(wr_flags && bus.wdata[mlt_pkg::FLG_CHZ_BIT])) ||
                       (tick && chz_evt && !wr_count);
      end
   end

   // equality pulse and toggling output
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         equ0_r <= 1'b0;
         out_r <= 1'b0;
      end else begin
         equ0_r <= tick && chz_evt && !wr_count;
         if (tick && chz_evt && !wr_count) begin
            out_r <= !out_r;
         end
      end
   end

   // read data, one cycle after the strobe, zero elsewhere
   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         rdata_r <= 16'h0000;
      end else if (bus.rd) begin
         case (bus.addr)
            mlt_pkg::OFS_CTRL: rdata_r <= 16'(ctrl_r);
            mlt_pkg::OFS_COUNT: rdata_r <= cnt_r;
            mlt_pkg::OFS_CHZ: rdata_r <= per_buf_r;
            mlt_pkg::OFS_FLAGS: rdata_r <= {14'h0000, chz_flag_r,
                                            ovf_flag_r};
            mlt_pkg::OFS_PERIOD: rdata_r <= per_r;
            default: rdata_r <= 16'h0000;
         endcase
      end else begin
         rdata_r <= 16'h0000;
      end
   end

   // outputs
   assign rdata = rdata_r;
   assign count_value = cnt_r;
   assign period_value = per_r;
   assign equ0 = equ0_r;
   assign overflow_interrupt_flag = ovf_flag_r;
   assign channel_interrupt_flag = chz_flag_r;
   assign timer_out = out_r;
   assign timer_out_oe = !ctrl_r.out_hiz;

endmodule

/* File: tb/mlt_timer_base_props.sv */
// port-level assertions for the multi-length timer base
`timescale 1ns/1ps
module mlt_timer_base_props (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [mlt_pkg::ADDR_W-1:0] addr,
   input wire logic [mlt_pkg::CNT_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [mlt_pkg::CNT_W-1:0] rdata,
   input wire logic aux_clock,
   input wire logic sub_main_clock,
   input wire logic external_timer_clock_pin,
   input wire logic [mlt_pkg::CNT_W-1:0] count_value,
   input wire logic [mlt_pkg::CNT_W-1:0] period_value,
   input wire logic equ0,
   input wire logic overflow_interrupt_flag,
   input wire logic channel_interrupt_flag,
   input wire logic timer_out,
   input wire logic timer_out_oe
);
   logic [1:0] len_r;
   logic [15:0] lmax;
   logic wr_ctl;
   logic wr_cnt;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // decoded write strobes and length mask
   assign wr_ctl = wr_en && addr == mlt_pkg::OFS_CTRL;
   assign wr_cnt = wr_en && addr == mlt_pkg::OFS_COUNT;
   assign lmax = len_r == mlt_pkg::LEN_8 ? mlt_pkg::MAX_8 :
                 len_r == mlt_pkg::LEN_10 ? mlt_pkg::MAX_10 :
                 len_r == mlt_pkg::LEN_12 ? mlt_pkg::MAX_12 : mlt_pkg::MAX_16;
   // length code of the last control write
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         len_r <= 2'h0;
      end else if (wr_ctl) begin
         len_r <= wdata[12:11];
      end
   end
   property p_rd_idle;
      !$past(rd_en) |-> rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside read");
   property p_rd_count;
      rd_en && addr == mlt_pkg::OFS_COUNT |=> rdata == $past(count_value);
   endproperty
   a_rd_count: assert property (p_rd_count)
      else $error("count readback wrong");
   property p_wr_count;
      wr_cnt |=> count_value == ($past(wdata) & $past(lmax));
   endproperty
   a_wr_count: assert property (p_wr_count)
      else $error("count write not masked or late");
   property p_clear;
      wr_ctl && wdata[mlt_pkg::CLR_BIT] |=> count_value == 16'h0000;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear did not zero count");
   property p_upper;
      $stable(len_r) && (($past(count_value) & ~lmax) == 16'h0000)
         |-> (count_value & ~lmax) == 16'h0000;
   endproperty
   a_upper: assert property (p_upper)
      else $error("count bits above length set");
   property p_step;
      !$past(wr_en) && !$stable(count_value) |->
         count_value == $past(count_value) + 16'h0001 ||
         count_value == $past(count_value) - 16'h0001 ||
         count_value == 16'h0000;
   endproperty
   a_step: assert property (p_step)
      else $error("count moved by more than one");
   property p_ovf_rise;
      $rose(overflow_interrupt_flag) |-> count_value == 16'h0000;
   endproperty
   a_ovf_rise: assert property (p_ovf_rise)
      else $error("overflow flag set away from zero");
   property p_chz_rise;
      $rose(channel_interrupt_flag) && $stable(period_value)
         |-> count_value == period_value;
   endproperty
   a_chz_rise: assert property (p_chz_rise)
      else $error("channel flag set away from period");
   property p_ovf_fall;
      $fell(overflow_interrupt_flag) |->
         $past(wr_en && addr == mlt_pkg::OFS_FLAGS && wdata[0]);
   endproperty
   a_ovf_fall: assert property (p_ovf_fall)
      else $error("overflow flag dropped without clear");
   property p_equ0;
      equ0 |-> count_value == period_value ##1 !equ0;
   endproperty
   a_equ0: assert property (p_equ0)
      else $error("compare pulse wrong");
   property p_oe;
      wr_ctl |=> timer_out_oe == !$past(wdata[15]);
   endproperty
   a_oe: assert property (p_oe)
      else $error("output enable does not follow control");
endmodule

bind mlt_timer_base mlt_timer_base_props mlt_chk_u (.clock, .rst_n, .addr,
   .wdata, .wr_en, .rd_en, .rdata, .aux_clock, .sub_main_clock,
   .external_timer_clock_pin, .count_value, .period_value, .equ0,
   .overflow_interrupt_flag, .channel_interrupt_flag, .timer_out,
   .timer_out_oe);

/* File: tb/mlt_testbench.sv */
// self-checking bench of the multi-length timer base
`timescale 1ns/1ps
module testbench;
   logic clock, rst_n, wr_en, rd_en, aux_clock, sub_main_clock;
   logic external_timer_clock_pin, equ0, overflow_interrupt_flag;
   logic channel_interrupt_flag, timer_out, timer_out_oe, t0;
   logic [mlt_pkg::ADDR_W-1:0] addr;
   logic [15:0] wdata, rdata, count_value, period_value, rv;
   logic [15:0] mx [4];
   int mismatches, cmp_count;

   mlt_timer_base dut_u (.clock, .rst_n, .addr, .wdata, .wr_en, .rd_en,
      .rdata, .aux_clock, .sub_main_clock, .external_timer_clock_pin,
      .count_value, .period_value, .equ0, .overflow_interrupt_flag,
      .channel_interrupt_flag, .timer_out, .timer_out_oe);

   // free-running system clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      @(negedge clock);
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      @(negedge clock);
      rv = rdata;
   endtask

   function automatic logic [15:0] ctl(input logic [1:0] m, s, d, l);
      return {3'h0, l, 1'b0, s, d, m, 4'h0};
   endfunction

   // drive one source level; inverted external idles high
   task automatic drv(input logic [1:0] s, input logic v);
      if (s == mlt_pkg::SRC_AUX) aux_clock <= v;
      else if (s == mlt_pkg::SRC_SUB) sub_main_clock <= v;
      else external_timer_clock_pin <= v ^ (s == mlt_pkg::SRC_EXT_INV);
   endtask

   task automatic pulse(input logic [1:0] s, input int n);
      repeat (n) begin
         @(posedge clock);
         drv(s, 1'b1);
         repeat (2) @(posedge clock);
         drv(s, 1'b0);
         @(posedge clock);
      end
      repeat (3) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic t_reset;
      chk(count_value, 16'h0000);
      chk(timer_out_oe, 1'b1);
      rd(8'h14);
      chk(rv, 16'h0000);
      wr(8'h14, 16'hFFFF);
      rd(mlt_pkg::OFS_COUNT);
      chk(rv, 16'h0000);
      wr(mlt_pkg::OFS_CTRL, 16'h8000);
      chk(timer_out_oe, 1'b0);
   endtask

   task automatic t_len;
      for (int i = 0; i < 4; i++) begin
         wr(mlt_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 2'h0, i[1:0]));
         wr(mlt_pkg::OFS_COUNT, 16'hFFFF);
         chk(count_value, mx[i]);
         rd(mlt_pkg::OFS_COUNT);
         chk(rv, mx[i]);
         chk(overflow_interrupt_flag, 1'b0);
         wr(mlt_pkg::OFS_CTRL, ctl(2'h2, 2'h0, 2'h0, i[1:0]));
         pulse(2'h0, 1);
         chk(count_value, 16'h0000);
         chk(overflow_interrupt_flag, 1'b1);
         pulse(2'h0, 1);
         chk(count_value, 16'h0001);
         wr(mlt_pkg::OFS_FLAGS, 16'h0003);
         chk(overflow_interrupt_flag, 1'b0);
      end
   endtask

   task automatic t_src;
      for (int s = 0; s < 4; s++) begin
         @(posedge clock);
         drv(s[1:0], 1'b0);
         wr(mlt_pkg::OFS_CTRL, ctl(2'h0, s[1:0], 2'h0, 2'h0) | 16'h0004);
         wr(mlt_pkg::OFS_CTRL, ctl(2'h2, s[1:0], 2'h0, 2'h0));
         pulse(s[1:0], 2);
         chk(count_value, 16'h0002);
         pulse((s == 0) ? 2'h1 : 2'h0, 1);
         chk(count_value, 16'h0002);
      end
      wr(mlt_pkg::OFS_CTRL, 16'h0000);
      @(posedge clock);
      external_timer_clock_pin <= 1'b0;
   endtask

   task automatic t_div;
      for (int d = 0; d < 4; d++) begin
         wr(mlt_pkg::OFS_CTRL, ctl(2'h2, 2'h0, d[1:0], 2'h0) | 16'h0004);
         chk(count_value, 16'h0000);
         pulse(2'h0, 8);
         chk(count_value, 16'h0008 >> d);
      end
      wr(mlt_pkg::OFS_CTRL, 16'h0000);
      pulse(2'h0, 2);
      chk(count_value, 16'h0001);
   endtask

   task automatic t_up;
      wr(mlt_pkg::OFS_CTRL, 16'h0004);
      wr(mlt_pkg::OFS_CHZ, 16'h0002);
      chk(period_value, 16'h0002);
      wr(mlt_pkg::OFS_FLAGS, 16'h0003);
      t0 = timer_out;
      wr(mlt_pkg::OFS_CTRL, ctl(2'h1, 2'h0, 2'h0, 2'h0));
      pulse(2'h0, 2);
      chk(count_value, 16'h0002);
      chk(channel_interrupt_flag, 1'b1);
      chk(overflow_interrupt_flag, 1'b0);
      chk(timer_out, !t0);
      pulse(2'h0, 1);
      chk(count_value, 16'h0000);
      chk(overflow_interrupt_flag, 1'b1);
      wr(mlt_pkg::OFS_FLAGS, 16'h0003);
      wr(mlt_pkg::OFS_COUNT, 16'h0002);
      chk(channel_interrupt_flag, 1'b0);
      wr(mlt_pkg::OFS_CTRL, 16'h0000);
      wr(mlt_pkg::OFS_COUNT, 16'h0010);
      wr(mlt_pkg::OFS_CTRL, ctl(2'h1, 2'h0, 2'h0, 2'h0));
      pulse(2'h0, 2);
      chk(count_value, 16'h0001);
      wr(mlt_pkg::OFS_CHZ, 16'h0000);
      pulse(2'h0, 1);
      chk(count_value, 16'h0001);
      wr(mlt_pkg::OFS_CHZ, 16'h0005);
      chk(count_value, 16'h0000);
      pulse(2'h0, 4);
      chk(count_value, 16'h0004);
      wr(mlt_pkg::OFS_CHZ, 16'h0002);
      pulse(2'h0, 2);
      chk(count_value <= 16'h0001, 1'b1);
      wr(mlt_pkg::OFS_CTRL, ctl(2'h1, 2'h0, 2'h0, 2'h0) | 16'h2000);
      wr(mlt_pkg::OFS_CHZ, 16'h0005);
      chk(period_value, 16'h0002);
      pulse(2'h0, 3);
      chk(period_value, 16'h0005);
   endtask

   task automatic t_updn;
      logic [15:0] seq [9];
      seq = '{1, 2, 3, 2, 1, 0, 1, 2, 3};
      wr(mlt_pkg::OFS_CTRL, 16'h0004);
      wr(mlt_pkg::OFS_CHZ, 16'h0003);
      wr(mlt_pkg::OFS_FLAGS, 16'h0003);
      wr(mlt_pkg::OFS_CTRL, ctl(2'h3, 2'h0, 2'h0, 2'h0));
      for (int i = 0; i < 9; i++) begin
         pulse(2'h0, 1);
         chk(count_value, seq[i]);
         if (i == 2) chk(channel_interrupt_flag, 1'b1);
         if (i == 4) chk(overflow_interrupt_flag, 1'b0);
         if (i == 5) chk(overflow_interrupt_flag, 1'b1);
      end
      pulse(2'h0, 1);
      wr(mlt_pkg::OFS_CTRL, 16'h0000);
      pulse(2'h0, 1);
      chk(count_value, 16'h0002);
      wr(mlt_pkg::OFS_CTRL, ctl(2'h3, 2'h0, 2'h0, 2'h0));
      pulse(2'h0, 1);
      chk(count_value, 16'h0001);
      wr(mlt_pkg::OFS_CTRL, ctl(2'h3, 2'h0, 2'h0, 2'h0) | 16'h0004);
      wr(mlt_pkg::OFS_COUNT, 16'h0002);
      pulse(2'h0, 1);
      chk(count_value, 16'h0003);
      wr(mlt_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 2'h0, 2'h3));
      wr(mlt_pkg::OFS_CHZ, 16'h01FF);
      wr(mlt_pkg::OFS_COUNT, 16'h00FE);
      wr(mlt_pkg::OFS_FLAGS, 16'h0003);
      wr(mlt_pkg::OFS_CTRL, ctl(2'h3, 2'h0, 2'h0, 2'h3));
      pulse(2'h0, 2);
      chk(count_value, 16'h0000);
      chk(overflow_interrupt_flag, 1'b1);
   endtask

   task automatic final_report;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // watchdog against a hung sequence
   initial begin
      #2000000;
      mismatches++;
      final_report;
   end

   // reset, then the scenarios in turn
   initial begin
      rst_n = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = '0;
      wdata = '0;
      aux_clock = 1'b0;
      sub_main_clock = 1'b0;
      external_timer_clock_pin = 1'b0;
      mx = '{16'hFFFF, 16'h0FFF, 16'h03FF, 16'h00FF};
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      t_reset;
      t_len;
      t_src;
      t_div;
      t_up;
      t_updn;
      final_report;
   end
endmodule
